// ---- logic/sew_pkg.sv ----
// Shared constants for the serial EEPROM write path: target end and controller end.
// Assumes one 200 MHz system clock on both ends and a two-wire link resolved in sew_bus_if.
package sew_pkg;

  // System clock and link timing
  localparam int SEW_CLK_NS = 5;
  localparam int SEW_CLK_KHZ = 1000000000 / (SEW_CLK_NS * 1000);
  localparam int SEW_SCL_MAX_KHZ = 400;
  // Quarter of the link clock period, rounded up so the rate never passes the limit
  localparam int SEW_QTR_CYCLES = (SEW_CLK_KHZ + 4 * SEW_SCL_MAX_KHZ - 1) / (4 * SEW_SCL_MAX_KHZ);
  localparam int SEW_PROG_MS = 5;
  // Longest programming time, rounded down to whole clock cycles
  localparam int SEW_PROG_CYCLES = (SEW_PROG_MS * 1000000) / SEW_CLK_NS;

  // Device address word; the type code value is arbitrary
  localparam logic [3:0] SEW_TYPE_CODE = 4'h6;

  // Word framing: eight data clocks, then the acknowledge clock
  localparam logic [3:0] SEW_ACK_IDX = 4'h8;
  localparam logic [3:0] SEW_END_IDX = 4'h9;

  // Memory layout
  localparam int SEW_ADDR_W = 13;
  localparam int SEW_PAGE_W = 5;
  localparam int SEW_PAGE_BYTES = 32;
  localparam logic [4:0] SEW_PAGE_LAST = 5'h1f;

  // Controller registers (byte offsets on the AHB-Lite port)
  localparam logic [7:0] SEW_REG_CTRL = 8'h00;
  localparam logic [7:0] SEW_REG_TX = 8'h04;
  localparam logic [7:0] SEW_REG_STAT = 8'h08;
  localparam logic [1:0] SEW_HTRANS_NONSEQ = 2'h2;

  // Controller commands, written to the low bits of the control register
  typedef enum logic [1:0] {
    sew_cmd_start,
    sew_cmd_stop,
    sew_cmd_write,
    sew_cmd_read
  } sew_cmd_e;

endpackage

// ---- logic/sew_bus_if.sv ----
// Two-wire link between the serial EEPROM target end and its controller end.
// Both data drivers are open drain; the line is pulled high when nobody pulls it low.
`timescale 1ns/1ps
`default_nettype none
interface sew_bus_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // Wired-AND of both drivers with the pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
endinterface
`default_nettype wire

// ---- logic/sew_dev_end.sv ----
// Serial EEPROM target end: start/stop, address match, page writes, protection, reads.
// Assumes the memory array sits outside, read combinationally through mem_raddr/mem_rdata.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sew_dev_end
  import sew_pkg::*;
#(
  parameter int PROG_CYCLES = SEW_PROG_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  sew_bus_if.dev bus,
  // Straps and protect, pulled low outside when left open
  input wire logic [2:0] strap_select_pins,
  input wire logic write_protect,
  // Memory array port
  output logic mem_we,
  output logic [SEW_ADDR_W-1:0] mem_waddr,
  output logic [7:0] mem_wdata,
  output logic [SEW_ADDR_W-1:0] mem_raddr,
  input wire logic [7:0] mem_rdata,
  // Status
  output logic prog_busy
);

  typedef enum logic [2:0] {st_idle, st_dev, st_ahi, st_alo, st_wdat, st_rdat,
    st_prog} sew_dev_st_e;

  sew_dev_st_e state, next_state, after_ack;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [2:0] strap_s1, strap_s2;
  logic prot_s1, prot_s2;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic host_nack, ack_ok;
  logic scl_rise, scl_fall, start_ev, stop_ev, active, byte_take, prog_done;
  logic [7:0] page_buf [SEW_PAGE_BYTES];
  logic [SEW_PAGE_BYTES-1:0] page_valid;
  logic [31:0] prog_cnt;
  logic [5:0] walk_idx;

  // Two flops on every link, strap and protect input before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7; // Idle high, so no false edge after reset
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {strap_s1, strap_s2} <= 6'h00;
      {prot_s1, prot_s2} <= 2'h0;
    end
    else
    begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, bus.scl};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, bus.sda};
      strap_s1 <= strap_select_pins;
      strap_s2 <= strap_s1;
      prot_s1 <= write_protect;
      prot_s2 <= prot_s1;
    end
  end

  // Edge and condition detection on the synchronised link
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_ev = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  // Busy programming makes the whole link invisible, polls included
  assign active = (state != st_idle) && (state != st_prog);
  assign prog_done = (state == st_prog) && (prog_cnt == 32'(PROG_CYCLES - 1));

  // Acknowledge decision and follow-on state, judged on the full byte
  always_comb
  begin
    ack_ok = 1'b1;
    after_ack = st_idle;
    unique case (state)
      st_dev:
      begin
        ack_ok = (shreg[7:4] == SEW_TYPE_CODE) && (shreg[3:1] == strap_s2);
        after_ack = !ack_ok ? st_idle : (shreg[0] ? st_rdat : st_ahi);
      end
      st_ahi: after_ack = st_alo;
      st_alo: after_ack = st_wdat;
      st_wdat:
      begin
        ack_ok = ~prot_s2;
        after_ack = prot_s2 ? st_idle : st_wdat;
      end
      st_rdat: after_ack = st_rdat;
      st_idle, st_prog: after_ack = st_idle;
    endcase
  end

  // A data byte goes into the page buffer on the fall that opens its acknowledge
  assign byte_take = active && !start_ev && !stop_ev && scl_fall && (bit_cnt == SEW_ACK_IDX)
    && (state == st_wdat) && !prot_s2;

  // Protocol engine: framing, acknowledge, address and read shifting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= st_idle;
      next_state <= st_idle;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      host_nack <= 1'b0;
      bus.dev_sda_o <= 1'b0; // Open drain: only the enable ever moves
      bus.dev_sda_oe_n <= 1'b1;
      mem_raddr <= '0;
      prog_busy <= 1'b0;
    end
    else if (state == st_prog)
    begin
      bus.dev_sda_oe_n <= 1'b1;
      if (prog_done)
      begin
        state <= st_idle;
        prog_busy <= 1'b0;
      end
    end
    else if (start_ev)
    begin
      // A repeated start restarts framing from any state except programming
      state <= st_dev;
      bit_cnt <= 4'h0;
      bus.dev_sda_oe_n <= 1'b1;
    end
    else if (stop_ev)
    begin
      bus.dev_sda_oe_n <= 1'b1;
      if (state == st_wdat && page_valid != '0)
      begin
        state <= st_prog;
        prog_busy <= 1'b1;
      end
      else
        state <= st_idle;
    end
    else if (active && scl_rise)
    begin
      bit_cnt <= bit_cnt + 4'h1;
      if (state != st_rdat && bit_cnt < SEW_ACK_IDX)
        shreg <= {shreg[6:0], sda_s2};
      if (state == st_rdat && bit_cnt == SEW_ACK_IDX)
      begin
        host_nack <= sda_s2;
        if (!sda_s2)
          mem_raddr <= mem_raddr + 13'h1;
      end
    end
    else if (active && scl_fall)
    begin
      if (bit_cnt == SEW_ACK_IDX)
      begin
        // Read: release for the controller's acknowledge; else answer it
        bus.dev_sda_oe_n <= (state == st_rdat) ? 1'b1 : ~ack_ok;
        next_state <= after_ack;
        if (state == st_ahi)
          mem_raddr[SEW_ADDR_W-1:8] <= shreg[SEW_ADDR_W-9:0];
        if (state == st_alo)
          mem_raddr[7:0] <= shreg;
        if (byte_take)
          mem_raddr[SEW_PAGE_W-1:0] <= mem_raddr[SEW_PAGE_W-1:0] + 5'h1;
      end
      else if (bit_cnt == SEW_END_IDX)
      begin
        bit_cnt <= 4'h0;
        if (next_state == st_rdat && (state == st_dev || !host_nack))
        begin
          state <= st_rdat;
          bus.dev_sda_oe_n <= mem_rdata[7];
          shreg <= {mem_rdata[6:0], 1'b0};
        end
        else
        begin
          // A refused read goes idle and stays quiet until the next start
          state <= (state == st_rdat) ? st_idle : next_state;
          bus.dev_sda_oe_n <= 1'b1;
        end
      end
      else if (state == st_rdat)
      begin
        bus.dev_sda_oe_n <= shreg[7];
        shreg <= {shreg[6:0], 1'b0};
      end
    end
  end

  // Page buffer; a start abandons bytes not yet committed by a stop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      page_valid <= '0;
    else if (prog_done || (start_ev && state != st_prog))
      page_valid <= '0;
    else if (byte_take)
      page_valid[mem_raddr[SEW_PAGE_W-1:0]] <= 1'b1;
  end

  // Buffer storage needs no reset; only valid entries are ever written out
  always_ff @(posedge hclk)
  begin
    if (byte_take)
      page_buf[mem_raddr[SEW_PAGE_W-1:0]] <= shreg;
  end

  // Programming cycle: write valid entries out, then hold busy for the full time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prog_cnt <= 32'h0;
      walk_idx <= 6'h0;
      mem_we <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= 8'h00;
    end
    else if (state != st_prog)
    begin
      prog_cnt <= 32'h0;
      walk_idx <= 6'h0;
      mem_we <= 1'b0;
    end
    else
    begin
      prog_cnt <= prog_cnt + 32'h1;
      mem_we <= 1'b0;
      if (!walk_idx[SEW_PAGE_W])
      begin
        mem_we <= page_valid[walk_idx[SEW_PAGE_W-1:0]];
        mem_waddr <= {mem_raddr[SEW_ADDR_W-1:SEW_PAGE_W], walk_idx[SEW_PAGE_W-1:0]};
        mem_wdata <= page_buf[walk_idx[SEW_PAGE_W-1:0]];
        walk_idx <= walk_idx + 6'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/sew_host_end.sv ----
// Two-wire controller end: AHB-Lite register slave that runs start, stop,
// byte write and byte read commands on the link, one at a time.
// Assumes a single AHB-Lite master; hready is this slave's own hreadyout.
`timescale 1ns/1ps
`default_nettype none
module sew_host_end
  import sew_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Link
  sew_bus_if.host bus
);

  sew_cmd_e cmd;
  logic ack_bit, busy, nack;
  logic [7:0] tx_byte, rx_byte, tx_sh;
  logic [1:0] qph;
  logic [3:0] bidx;
  logic [7:0] div_cnt;
  logic tick;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic launch;
  logic sda_s1, sda_s2;

  // Quarter-period enable; four of them make one link clock of at most 400 kHz
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt <= 8'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (div_cnt == 8'(SEW_QTR_CYCLES - 1));
      div_cnt <= (div_cnt == 8'(SEW_QTR_CYCLES - 1)) ? 8'h0 : div_cnt + 8'h1;
    end
  end

  // Data line comes back through the wire, so it is synchronised
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // Zero-wait slave: address phase latched, read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      if (hsel && hready && htrans == SEW_HTRANS_NONSEQ)
      begin
        wr_pend <= hwrite;
        wr_addr <= haddr[7:0];
        unique case (haddr[7:0])
          SEW_REG_CTRL: hrdata <= {29'h0, ack_bit, cmd};
          SEW_REG_TX: hrdata <= {24'h0, tx_byte};
          SEW_REG_STAT: hrdata <= {16'h0, rx_byte, 6'h0, nack, busy};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Control writes while a command runs are dropped
  assign launch = wr_pend && (wr_addr == SEW_REG_CTRL) && !busy;

  // Transmit byte register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_byte <= 8'h0;
    else if (wr_pend && wr_addr == SEW_REG_TX)
      tx_byte <= hwdata[7:0];
  end

  // Bit engine: q0 sets data with clock low, q1 raises clock, q2 samples or moves data, q3 lowers clock except on stop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd <= sew_cmd_start;
      ack_bit <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      rx_byte <= 8'h0;
      tx_sh <= 8'h0;
      qph <= 2'h0;
      bidx <= 4'h0;
      bus.scl <= 1'b1;
      bus.host_sda_o <= 1'b0;
      bus.host_sda_oe_n <= 1'b1;
    end
    else if (launch)
    begin
      busy <= 1'b1;
      cmd <= sew_cmd_e'(hwdata[1:0]);
      ack_bit <= hwdata[2];
      tx_sh <= tx_byte;
      qph <= 2'h0;
      bidx <= 4'h0;
    end
    else if (busy && tick)
    begin
      qph <= qph + 2'h1;
      unique case (qph)
        2'h0:
        begin
          unique case (cmd)
            sew_cmd_start: bus.host_sda_oe_n <= 1'b1;
            sew_cmd_stop: bus.host_sda_oe_n <= 1'b0;
            sew_cmd_write: bus.host_sda_oe_n <= (bidx < SEW_ACK_IDX) ? tx_sh[7] : 1'b1;
            sew_cmd_read: bus.host_sda_oe_n <= (bidx < SEW_ACK_IDX) ? 1'b1 : ack_bit;
          endcase
        end
        2'h1: bus.scl <= 1'b1;
        2'h2:
        begin
          unique case (cmd)
            sew_cmd_start: bus.host_sda_oe_n <= 1'b0;
            sew_cmd_stop: bus.host_sda_oe_n <= 1'b1;
            sew_cmd_write:
            begin
              tx_sh <= {tx_sh[6:0], 1'b0};
              if (bidx == SEW_ACK_IDX)
                nack <= sda_s2;
            end
            sew_cmd_read:
            begin
              if (bidx < SEW_ACK_IDX)
                rx_byte <= {rx_byte[6:0], sda_s2};
            end
          endcase
        end
        2'h3:
        begin
          if (cmd != sew_cmd_stop)
            bus.scl <= 1'b0;
          if (cmd == sew_cmd_start || cmd == sew_cmd_stop || bidx == SEW_ACK_IDX)
            busy <= 1'b0;
          else
            bidx <= bidx + 4'h1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- tb/sew_link_props.sv ----
// Link checker for the serial EEPROM write path.
// Assumes the resolved two-wire link plus two status nets of the target end.
`timescale 1ns/1ps
`default_nettype none
module sew_link_props
  import sew_pkg::*;
#(
  parameter int PROG_CYCLES = SEW_PROG_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  // Target status
  input wire logic prog_busy,
  input wire logic mem_we
);
  localparam int MIN_PERIOD = 1000000 / (SEW_SCL_MAX_KHZ * SEW_CLK_NS);
  logic scl_q;
  logic seen_rise;
  logic [15:0] per_cnt;
  logic [31:0] busy_cnt;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Cycles since the last clock rise; saturates so long idles cannot wrap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_q <= 1'b1;
      seen_rise <= 1'b0;
      per_cnt <= 16'h0;
    end
    else
    begin
      scl_q <= scl;
      if (scl && !scl_q)
      begin
        seen_rise <= 1'b1;
        per_cnt <= 16'h1;
      end
      else if (per_cnt != 16'hffff)
        per_cnt <= per_cnt + 16'h1;
    end
  end

  // Length of the current programming cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= prog_busy ? busy_cnt + 32'h1 : 32'h0;
  end

  property p_dev_low_only; !dev_sda_oe_n |-> !dev_sda_o; endproperty
  a_dev_low_only: assert property (p_dev_low_only)
    else $error("target drives the data line high");
  property p_host_low_only; !host_sda_oe_n |-> !host_sda_o; endproperty
  a_host_low_only: assert property (p_host_low_only)
    else $error("controller drives the data line high");
  property p_dev_steady; scl && $past(scl) |-> $stable(dev_sda_oe_n); endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("target moved the data line while clock high");
  property p_period; scl && !scl_q && seen_rise |-> per_cnt >= MIN_PERIOD; endproperty
  a_period: assert property (p_period)
    else $error("link clock period too short");
  property p_start; $fell(sda) && scl |-> ##1 scl [*8]; endproperty
  a_start: assert property (p_start)
    else $error("clock fell right after start");
  property p_stop; $rose(sda) && scl |-> ##1 scl [*8]; endproperty
  a_stop: assert property (p_stop)
    else $error("clock fell right after stop");
  property p_busy_quiet; prog_busy |-> dev_sda_oe_n; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("target drove the line while programming");
  property p_prog_len; prog_busy |-> busy_cnt <= PROG_CYCLES; endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programming cycle too long");
  property p_we_in_prog; mem_we |-> prog_busy; endproperty
  a_we_in_prog: assert property (p_we_in_prog)
    else $error("array written outside programming");
  property p_prog_writes; $rose(prog_busy) |-> ##[1:33] mem_we; endproperty
  a_prog_writes: assert property (p_prog_writes)
    else $error("programming wrote nothing");

  c_ack: cover property ($fell(dev_sda_oe_n));
  c_prog: cover property ($rose(prog_busy));
  c_write: cover property (mem_we);
endmodule
`default_nettype wire

// ---- tb/tb_serial_eeprom_bus_write_logic.sv ----
// Bench for the serial EEPROM write path: controller end driven over AHB-Lite,
// target end facing it on the link, array modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_bus_write_logic
  import sew_pkg::*;
;
  localparam int PROG = 7000;
  localparam logic [7:0] DEV_W = {SEW_TYPE_CODE, 3'h5, 1'b0};
  localparam logic [7:0] DEV_R = {SEW_TYPE_CODE, 3'h5, 1'b1};
  localparam logic [7:0] DEV_X = {SEW_TYPE_CODE, 3'h4, 1'b0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [2:0] straps = 3'h5;
  logic wp = 1'b0;
  logic mem_we;
  logic [12:0] mem_waddr;
  logic [12:0] mem_raddr;
  logic [7:0] mem_wdata;
  logic prog_busy;
  logic [7:0] mem [0:8191];
  logic [31:0] st;
  int n_mismatch = 0;
  int checks = 0;
  int n_we = 0;

  sew_bus_if i_sew_bus_if ();
  sew_host_end i_sew_host_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(i_sew_bus_if.host));
  sew_dev_end #(.PROG_CYCLES(PROG)) i_sew_dev_end (.hclk(hclk), .hresetn(hresetn),
    .bus(i_sew_bus_if.dev), .strap_select_pins(straps), .write_protect(wp), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_raddr(mem_raddr),
    .mem_rdata(mem[mem_raddr]), .prog_busy(prog_busy));
  sew_link_props #(.PROG_CYCLES(PROG)) i_sew_link_props (.hclk(hclk), .hresetn(hresetn),
    .scl(i_sew_bus_if.scl), .sda(i_sew_bus_if.sda), .host_sda_o(i_sew_bus_if.host_sda_o),
    .host_sda_oe_n(i_sew_bus_if.host_sda_oe_n), .dev_sda_o(i_sew_bus_if.dev_sda_o),
    .dev_sda_oe_n(i_sew_bus_if.dev_sda_oe_n), .prog_busy(prog_busy), .mem_we(mem_we));

  // 200 MHz clock
  initial
  begin
    forever #2.5 hclk = ~hclk;
  end

  // Array model, counting every byte committed
  always @(posedge hclk)
  begin
    if (mem_we === 1'b1)
    begin
      mem[mem_waddr] <= mem_wdata;
      n_we <= n_we + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Timeouts count as a mismatch and end the run
  task automatic bail(input int i, input int lim);
    if (i >= lim)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // Wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 20; i++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    bail(i, 20);
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= SEW_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Issue a link command and poll until the controller is idle
  task automatic run(input sew_cmd_e c, input logic ackb);
    int i;
    ahb(1'b1, SEW_REG_CTRL, {29'h0, ackb, c}, st);
    for (i = 0; i < 3000; i++)
    begin
      ahb(1'b0, SEW_REG_STAT, 32'h0, st);
      if (st[0] === 1'b0)
        break;
    end
    bail(i, 3000);
  endtask

  // Send one byte and compare the acknowledge the target gave
  task automatic wbyte(input logic [7:0] b, input logic exp_nack);
    ahb(1'b1, SEW_REG_TX, {24'h0, b}, st);
    run(sew_cmd_write, 1'b0);
    chk({31'h0, st[1]}, {31'h0, exp_nack});
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < PROG + 100; i++)
    begin
      @(posedge hclk);
      if (prog_busy === 1'b0)
        break;
    end
    bail(i, PROG + 100);
  endtask

  // Main sequence; the array starts erased so unwritten bytes read as ff
  initial
  begin
    for (int k = 0; k < 8192; k++)
      mem[k] = 8'hff;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    ahb(1'b0, SEW_REG_STAT, 32'h0, st);
    chk(st, 32'h0);
    ahb(1'b0, 8'h0c, 32'h0, st);
    chk(st, 32'h0);
    // Page write from offset 1f with stray high address bits; second byte wraps
    run(sew_cmd_start, 1'b0);
    wbyte(DEV_W, 1'b0);
    wbyte(8'hf2, 1'b0);
    wbyte(8'h1f, 1'b0);
    wbyte(8'h3c, 1'b0);
    wbyte(8'hc3, 1'b0);
    ahb(1'b0, SEW_REG_TX, 32'h0, st);
    chk(st, 32'hc3);
    run(sew_cmd_stop, 1'b0);
    // A poll while programming gets no acknowledge
    run(sew_cmd_start, 1'b0);
    wbyte(DEV_W, 1'b1);
    chk({31'h0, prog_busy}, 32'h1);
    run(sew_cmd_stop, 1'b0);
    wait_idle();
    chk(n_we, 2);
    chk({24'h0, mem[13'h121f]}, 32'h3c);
    chk({24'h0, mem[13'h1200]}, 32'hc3);
    // Poll after programming is acknowledged; then a protected write
    run(sew_cmd_start, 1'b0);
    wbyte(DEV_W, 1'b0);
    wp <= 1'b1;
    wbyte(8'h12, 1'b0);
    wbyte(8'h05, 1'b0);
    wbyte(8'h77, 1'b1);
    run(sew_cmd_stop, 1'b0);
    repeat (50) @(posedge hclk);
    chk({31'h0, prog_busy}, 32'h0);
    chk(n_we, 2);
    // Wrong strap code is ignored; random and sequential reads work while protected
    run(sew_cmd_start, 1'b0);
    wbyte(DEV_X, 1'b1);
    run(sew_cmd_start, 1'b0);
    wbyte(DEV_W, 1'b0);
    wbyte(8'h12, 1'b0);
    wbyte(8'h1f, 1'b0);
    run(sew_cmd_start, 1'b0);
    wbyte(DEV_R, 1'b0);
    run(sew_cmd_read, 1'b0);
    chk({24'h0, st[15:8]}, 32'h3c);
    run(sew_cmd_read, 1'b1);
    chk({24'h0, st[15:8]}, 32'hff);
    ahb(1'b0, SEW_REG_CTRL, 32'h0, st);
    chk(st, 32'h7);
    run(sew_cmd_stop, 1'b0);
    wp <= 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
